// ---- core/ast_tx_top.sv ----
// Asynchronous serial transmitter with APB register access.
// Assumes a zero-wait APB master on pclk and a receiver at the same rate.
`timescale 1ns/1ns
`default_nettype none

module ast_tx_top
    import ast_pkg::*;
(
    input  wire logic        pclk,        // System clock, 50 MHz.
    input  wire logic        presetn,     // Asynchronous reset, active low.
    input  wire logic        psel,        // APB select.
    input  wire logic        penable,     // APB access phase.
    input  wire logic        pwrite,      // APB direction, high for write.
    input  wire logic [11:0] paddr,       // APB byte address.
    input  wire logic [31:0] pwdata,      // APB write data.
    output logic      [31:0] prdata,      // APB read data.
    output logic             pready,      // APB ready, always high.
    output logic             pslverr,     // APB error on unmapped address.
    output logic             tx_pin_o,    // Serial output level.
    output logic             tx_pin_oe,   // Serial pin drive enable.
    output logic             tx_irq       // Buffer-empty interrupt request.
);

    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic [CTRL_W-1:0] ctrl_r;
    logic [15:0]       baud_r;
    logic [CHAR_W-1:0] hold_data_r;
    logic              hold_full_r;
    logic              empty_flag_r;
    logic [31:0]       prdata_r;
    logic              pslverr_r;
    logic              setup;
    logic              wr_acc;
    logic              mapped;
    logic              data_wr;
    ast_state_type     state_r;
    logic              state_idle;

    assign setup   = psel && !penable;
    assign wr_acc  = psel && penable && pwrite;
    assign mapped  = (paddr == REG_CTRL_OFS) || (paddr == REG_BAUD_OFS) ||
                     (paddr == REG_DATA_OFS) || (paddr == REG_STAT_OFS);
    assign data_wr = wr_acc && (paddr == REG_DATA_OFS);
    assign pready  = 1'b1;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;

    logic tx_en;
    logic sync_mode;
    logic port_en;
    logic invert;
    logic nine_bits;
    logic stop2;
    logic irq_en;
    logic active;

    assign tx_en     = ctrl_r[CTRL_TX_ENABLE_BIT_BIT];
    assign sync_mode = ctrl_r[CTRL_SYNC_BIT];
    assign port_en   = ctrl_r[CTRL_PORT_MASTER_ENABLE_BIT];
    assign invert    = ctrl_r[CTRL_INV_BIT];
    assign nine_bits = ctrl_r[CTRL_NINE_BIT];
    assign stop2     = ctrl_r[CTRL_STOP2_BIT];
    assign irq_en    = ctrl_r[CTRL_IRQEN_BIT];
    // All three enables must agree before anything is shifted.
    assign active    = tx_en && port_en && !sync_mode;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_acc && paddr == REG_CTRL_OFS) begin
            ctrl_r <= pwdata[CTRL_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_r <= BAUD_RESET;
        end else if (wr_acc && paddr == REG_BAUD_OFS) begin
            baud_r <= pwdata[15:0];
        end
    end

    // Read data is captured in the setup cycle so it is stable for the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            pslverr_r <= !mapped;
            prdata_r  <= 32'h0000_0000;
            unique case (paddr)
                REG_CTRL_OFS: prdata_r[CTRL_W-1:0] <= ctrl_r;
                REG_BAUD_OFS: prdata_r[15:0] <= baud_r;
                REG_DATA_OFS: prdata_r[CHAR_W-1:0] <= hold_data_r;
                REG_STAT_OFS: begin
                    prdata_r[STAT_EMPTY_BIT] <= empty_flag_r;
                    prdata_r[STAT_BUSY_BIT]  <= !state_idle;
                    prdata_r[STAT_FULL_BIT]  <= hold_full_r;
                    prdata_r[STAT_IRQ_BIT]   <= tx_irq;
                end
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // Baud generator
    // ****************************************************************
    ast_baud_if #(.DIV_W(16)) bif ();
    logic          tick;

    assign state_idle    = (state_r == ST_IDLE);
    assign bif.run       = active && !state_idle;
    assign bif.wide_mode = ctrl_r[CTRL_WIDE_BIT];
    assign bif.divisor   = baud_r;
    assign tick          = bif.tick;

    ast_baud_gen #(.DIV_W(16)) u_baud (
        .pclk    (pclk),
        .presetn (presetn),
        .bif     (bif)
    );

    // ****************************************************************
    // Holding buffer and shifter
    // ****************************************************************
    logic [CHAR_W-1:0] shreg_r;
    logic [3:0]        bit_cnt_r;
    logic              stop_cnt_r;
    logic [3:0]        last_bit;
    logic              data_done;
    logic              stop_done;
    logic              load;

    assign last_bit  = nine_bits ? LAST_BIT_9 : LAST_BIT_8;
    assign data_done = tick && (bit_cnt_r == last_bit);
    assign stop_done = tick && (stop_cnt_r == stop2);
    // A queued character moves in at the end of the stop bit, with no idle gap.
    assign load = active && hold_full_r &&
                  (state_idle || (state_r == ST_STOP && stop_done));

    // A write arriving with a load keeps the buffer full with the new character.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_full_r <= 1'b0;
        end else if (!active) begin
            hold_full_r <= 1'b0;
        end else if (data_wr) begin
            hold_full_r <= 1'b1;
        end else if (load) begin
            hold_full_r <= 1'b0;
        end
    end

    // The ninth bit is stored as written; parity is software's job.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_data_r <= '0;
        end else if (data_wr) begin
            hold_data_r <= pwdata[CHAR_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
        end else if (!active) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE:  if (load) state_r <= ST_START;
                ST_START: if (tick) state_r <= ST_DATA;
                ST_DATA:  if (data_done) state_r <= ST_STOP;
                ST_STOP: begin
                    if (stop_done) state_r <= hold_full_r ? ST_START : ST_IDLE;
                end
                default:  state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shreg_r <= '0;
        end else if (load) begin
            shreg_r <= hold_data_r;
        end else if (state_r == ST_DATA && tick) begin
            shreg_r <= {1'b0, shreg_r[CHAR_W-1:1]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_r  <= 4'h0;
            stop_cnt_r <= 1'b0;
        end else if (load || !active) begin
            bit_cnt_r  <= 4'h0;
            stop_cnt_r <= 1'b0;
        end else if (tick && state_r == ST_DATA) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
        end else if (tick && state_r == ST_STOP) begin
            stop_cnt_r <= !stop_cnt_r;
        end
    end

    // ****************************************************************
    // Line driver
    // ****************************************************************
    logic line;
    logic tx_out_r;

    always_comb begin
        unique case (state_r)
            ST_START: line = 1'b0;
            ST_DATA:  line = shreg_r[0];
            default:  line = 1'b1;
        endcase
    end

    // The line is registered, so every bit is delayed by one cycle but keeps its length.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_out_r <= 1'b1;
        end else begin
            tx_out_r <= line ^ (invert && !sync_mode);
        end
    end

    assign tx_pin_o  = tx_out_r;
    assign tx_pin_oe = port_en;

    // ****************************************************************
    // Buffer-empty flag
    // ****************************************************************
    // Registered one cycle behind the buffer, so a write shows up on the second cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            empty_flag_r <= 1'b0;
        end else begin
            empty_flag_r <= tx_en && !(hold_full_r && !state_idle);
        end
    end

    assign tx_irq = empty_flag_r && irq_en;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [16:0] len_cnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_cnt_r <= '0;
        end else if (tick || state_idle) begin
            len_cnt_r <= '0;
        end else begin
            len_cnt_r <= len_cnt_r + 17'h1;
        end
    end

    a_idle_mark_level: assert property (
        state_idle && $past(state_idle) |=> tx_pin_o == !($past(invert) && !$past(sync_mode)))
        else $error("idle line not at mark level");
    a_start_bit_space: assert property (
        state_r == ST_START && !invert |=> tx_pin_o == 1'b0)
        else $error("start bit not at space level");
    a_bit_period_len: assert property (
        tick |-> len_cnt_r == (bif.wide_mode ? {1'b0, baud_r} : {9'h000, baud_r[7:0]}))
        else $error("bit period length wrong");
    a_lsb_first_shift: assert property (
        state_r == ST_DATA && tick && !load |=> shreg_r == {1'b0, $past(shreg_r[CHAR_W-1:1])})
        else $error("data not shifted lsb first");
    a_pin_output_en: assert property (
        wr_acc && paddr == REG_CTRL_OFS |=> tx_pin_oe == $past(pwdata[CTRL_PORT_MASTER_ENABLE_BIT]))
        else $error("pin enable does not follow port enable");
    a_enable_sets_flag: assert property (
        $rose(tx_en) && !hold_full_r |=> empty_flag_r)
        else $error("enable did not set empty flag");
    a_idle_write_load: assert property (
        active && state_idle && data_wr |=> ##1 state_r == ST_START)
        else $error("idle write did not start a frame");
    a_stop_to_start: assert property (
        state_r == ST_STOP && stop_done && hold_full_r && active |=> state_r == ST_START)
        else $error("queued character not loaded at stop end");
    a_flag_delay_two: assert property (
        data_wr && active && !state_idle && !(state_r == ST_STOP && stop_done) |->
            empty_flag_r == $past(empty_flag_r) ##2 !empty_flag_r)
        else $error("empty flag timing wrong");
    a_irq_gated: assert property (
        tx_irq |-> irq_en && empty_flag_r)
        else $error("irq without enable");
    a_disable_idles: assert property (
        !active |=> state_idle && !hold_full_r)
        else $error("disable did not reset shifter");

endmodule // ast_tx_top

`default_nettype wire

// ---- core/ast_pkg.sv ----
// Constants, register map and state codes of the asynchronous serial transmitter.
// Assumes an APB master on pclk and a remote receiver on the serial line.
// Function
// - Idle line sits at mark level, the level of a one bit.
// - Frame is start bit at space, eight or nine data bits, stop bits.
// - Every bit lasts exactly one bit period of the baud generator.
// - Baud generator divides pclk, selectable eight-bit or sixteen-bit divisor.
// - Data bits go out least significant bit first.
// - No hardware parity; software places parity in the ninth data bit.
// - Port master enable turns the shared transmit pin into an output.
// - Setting transmit enable sets the buffer-empty flag at once.
// - Buffer write starts a frame; idle shifter takes the character immediately.
// - Queued character loads at stop end; its start bit follows at once.
// - Invert select resets to zero; one inverts idle level and data.
// - Invert select acts on polarity in asynchronous operation only.
// - Empty flag clear only while transmit is disabled or while shifting with another character queued.
// - Empty flag becomes valid on the second cycle after the write.
// - Empty flag is read-only; software writes do not touch it.
// - Interrupt request needs irq enable; flag follows buffer regardless.
`default_nettype none

package ast_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] REG_CTRL_OFS  = 12'h000;
    localparam logic [11:0] REG_BAUD_OFS  = 12'h004;
    localparam logic [11:0] REG_DATA_OFS  = 12'h008;
    localparam logic [11:0] REG_STAT_OFS  = 12'h00c;

    localparam int CTRL_TX_ENABLE_BIT_BIT   = 0;
    localparam int CTRL_SYNC_BIT   = 1;
    localparam int CTRL_PORT_MASTER_ENABLE_BIT   = 2;
    localparam int CTRL_INV_BIT    = 3;
    localparam int CTRL_NINE_BIT   = 4;
    localparam int CTRL_WIDE_BIT   = 5;
    localparam int CTRL_IRQEN_BIT  = 6;
    localparam int CTRL_STOP2_BIT  = 7;
    localparam int CTRL_W          = 8;

    localparam int STAT_EMPTY_BIT  = 0;
    localparam int STAT_BUSY_BIT   = 1;
    localparam int STAT_FULL_BIT   = 2;
    localparam int STAT_IRQ_BIT    = 3;

    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [15:0] BAUD_RESET    = 16'h0019;
    localparam int          CHAR_W        = 9;
    localparam logic [3:0]  LAST_BIT_8    = 4'h7;
    localparam logic [3:0]  LAST_BIT_9    = 4'h8;

    // ****************************************************************
    // Shifter states
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_START = 4'b0010,
        ST_DATA  = 4'b0100,
        ST_STOP  = 4'b1000
    } ast_state_type;

endpackage

`default_nettype wire

// ---- core/ast_baud_if.sv ----
// Interface between the transmitter core and its baud generator.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ns
`default_nettype none

interface ast_baud_if #(parameter int DIV_W = 16);
    logic             run;
    logic             wide_mode;
    logic [DIV_W-1:0] divisor;
    logic             tick;
    modport gen  (input run, input wide_mode, input divisor, output tick);
    modport user (output run, output wide_mode, output divisor, input tick);
endinterface

`default_nettype wire

// ---- core/ast_baud_gen.sv ----
// Baud generator: one tick per bit period while the shifter runs.
// Assumes divisor is stable during a frame.
`timescale 1ns/1ns
`default_nettype none

module ast_baud_gen
    import ast_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input  wire logic pclk,     // System clock.
    input  wire logic presetn,  // Asynchronous reset, active low.
    ast_baud_if.gen   bif       // Run, mode, divisor and tick.
);
    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] limit;

    // The narrow mode pads the low byte to sixteen bits, so no other width is served.
    if (DIV_W != 16) begin : g_div_check
        $error("ast_baud_gen needs a sixteen-bit divisor");
    end

    // Narrow mode uses only the low byte, so the period is low byte plus one.
    assign limit    = bif.wide_mode ? bif.divisor : {8'h00, bif.divisor[7:0]};
    assign bif.tick = bif.run && (cnt_r == limit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else if (!bif.run || bif.tick) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule // ast_baud_gen

`default_nettype wire

// ---- verification/ast_rx_model.sv ----
// Behavioural receiver at the far end of the serial line.
// Assumes the bench sets bit period, width, stop count and polarity.
`timescale 1ns/1ns
`default_nettype none

module ast_rx_model (
    input  wire logic        pclk,     // System clock.
    input  wire logic        line,     // Serial line level.
    input  wire logic [15:0] period,   // Bit period in pclk cycles.
    input  wire logic        nine,     // Nine data bits.
    input  wire logic        inv,      // Inverted polarity.
    input  wire logic        stop2,    // Two stop bits.
    output logic      [8:0]  rx_data,  // Received character.
    output logic             rx_valid, // One-cycle strobe per character.
    output logic             rx_ferr   // Stop bit not at mark.
);
    // ****************************************************************
    // Receiver
    // ****************************************************************
    logic lv;
    assign lv = line ^ inv;

    // A low shorter than half a bit is dropped, so polarity switches and aborts are not frames.
    always begin
        logic [8:0] acc;
        logic       ok;
        @(posedge pclk);
        rx_valid <= 1'b0;
        if (lv === 1'b0) begin
            repeat (period / 2) @(posedge pclk);
            if (lv === 1'b0) begin
                acc = 9'h000;
                for (int i = 0; i < (nine ? 9 : 8); i++) begin
                    repeat (period) @(posedge pclk);
                    acc[i] = lv;
                end
                repeat (period) @(posedge pclk);
                ok = (lv === 1'b1);
                if (stop2) begin
                    repeat (period) @(posedge pclk);
                    ok = ok & (lv === 1'b1);
                end
                rx_data  <= acc;
                rx_ferr  <= ~ok;
                rx_valid <= 1'b1;
            end
        end
    end
endmodule // ast_rx_model

`default_nettype wire

// ---- verification/tb_async_serial_transmitter.sv ----
// Self-checking bench for the asynchronous serial transmitter.
// Assumes ast_pkg, the design files and ast_rx_model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module tb_async_serial_transmitter
    import ast_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tx_pin_o;
    logic        tx_pin_oe;
    logic        tx_irq;
    logic [15:0] m_period;
    logic        m_nine;
    logic        m_inv;
    logic        m_stop2;
    logic [8:0]  rx_data;
    logic        rx_valid;
    logic        rx_ferr;
    logic [8:0]  exp_q[$];
    int          n_errors;
    int          compares;

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        m_period = 16'd10;
        m_nine = 1'b0;
        m_inv = 1'b0;
        m_stop2 = 1'b0;
        n_errors = 0;
        compares = 0;
    end

    always #10 pclk = ~pclk;

    ast_tx_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe), .tx_irq(tx_irq));

    ast_rx_model u_rx (.pclk(pclk), .line(tx_pin_o), .period(m_period), .nine(m_nine),
        .inv(m_inv), .stop2(m_stop2), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ferr(rx_ferr));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk({31'h0, pready}, 32'h1, "ready");
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    function automatic logic [31:0] cfg(input logic [7:0] extra);
        cfg = {24'h0, extra};
        cfg[CTRL_TX_ENABLE_BIT_BIT] = 1'b1;
        cfg[CTRL_PORT_MASTER_ENABLE_BIT] = 1'b1;
    endfunction

    task drain(input string s);
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(exp_q.size()), 32'h0, "frames left over");
        repeat (m_period) @(posedge pclk);
        $display("Test %s finished", s);
    endtask

    task end_sim;
        $display("Comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ****************************************************************
    // Checker of received characters
    // ****************************************************************
    always @(posedge pclk) begin
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0)
                chk({23'h0, rx_data}, 32'hffff_ffff, "unexpected frame");
            else
                chk({22'h0, rx_ferr, rx_data}, {23'h0, exp_q.pop_front()}, "char");
        end
    end

    initial begin
        #(30000 * 20);
        n_errors++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim;
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        logic [31:0] r;
        logic        e;
        logic [8:0]  d0;
        logic [8:0]  d1;
        logic [7:0]  ex;
        void'($urandom(32'h4ecd));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        chk({31'h0, tx_pin_o}, 32'h1, "idle after reset");
        chk({31'h0, tx_pin_oe}, 32'h0, "oe after reset");
        rd(REG_CTRL_OFS, r);
        chk(r, 32'h0, "ctrl reset");
        rd(REG_BAUD_OFS, r);
        chk(r, {16'h0, BAUD_RESET}, "baud reset");
        apb(1'b0, 12'h010, 32'h0, r, e);
        chk({e, r[30:0]}, 32'h80000000, "unmapped");
        wr(REG_STAT_OFS, 32'hf);
        rd(REG_STAT_OFS, r);
        chk({31'h0, r[STAT_EMPTY_BIT]}, 32'h0, "flag write");
        // The high byte is set on purpose: eight-bit mode must ignore it.
        wr(REG_BAUD_OFS, 32'h0109);
        // The bench line has no analog function, so there is no analog select to clear.
        wr(REG_CTRL_OFS, cfg(8'h00));
        rd(REG_STAT_OFS, r);
        chk({31'h0, r[STAT_EMPTY_BIT]}, 32'h1, "flag on enable");
        chk({31'h0, tx_pin_oe}, 32'h1, "oe");
        $display("Test reset and enable finished");
        for (int m = 0; m < 4; m++) begin
            ex = (m == 0) ? 8'h00 : 8'(1 << (m == 1 ? CTRL_NINE_BIT :
                                         m == 2 ? CTRL_STOP2_BIT : CTRL_INV_BIT));
            wr(REG_CTRL_OFS, cfg(ex | 8'(1 << CTRL_IRQEN_BIT)));
            m_nine <= ex[CTRL_NINE_BIT];
            m_stop2 <= ex[CTRL_STOP2_BIT];
            m_inv <= ex[CTRL_INV_BIT];
            repeat (20) @(posedge pclk);
            chk({31'h0, tx_pin_o}, {31'h0, ~ex[CTRL_INV_BIT]}, "idle level");
            d0 = 9'($urandom);
            d1 = 9'($urandom);
            d0[8] = d0[8] & ex[CTRL_NINE_BIT];
            d1[8] = d1[8] & ex[CTRL_NINE_BIT];
            exp_q.push_back(d0);
            exp_q.push_back(d1);
            wr(REG_DATA_OFS, {23'h0, d0});
            wr(REG_DATA_OFS, {23'h0, d1});
            repeat (2) @(posedge pclk);
            rd(REG_STAT_OFS, r);
            chk({28'h0, r[STAT_IRQ_BIT], r[STAT_FULL_BIT], r[STAT_BUSY_BIT], r[STAT_EMPTY_BIT]},
                32'h6, "queued");
            chk({31'h0, tx_irq}, 32'h0, "irq while queued");
            r = 32'h4;
            for (int n = 0; n < 500 && r[STAT_FULL_BIT] !== 1'b0; n++)
                rd(REG_STAT_OFS, r);
            repeat (2) @(posedge pclk);
            chk({31'h0, tx_irq}, 32'h1, "irq when loaded");
            wr(REG_CTRL_OFS, cfg(ex));
            rd(REG_STAT_OFS, r);
            chk({30'h0, r[STAT_EMPTY_BIT], tx_irq}, 32'h2, "irq masked");
            drain("frame format");
        end
        wr(REG_BAUD_OFS, 32'h0107);
        wr(REG_CTRL_OFS, cfg(8'(1 << CTRL_WIDE_BIT)));
        m_inv <= 1'b0;
        m_nine <= 1'b0;
        m_stop2 <= 1'b0;
        m_period <= 16'd264;
        repeat (300) @(posedge pclk);
        d0 = {1'b0, 8'($urandom)};
        exp_q.push_back(d0);
        wr(REG_DATA_OFS, {23'h0, d0});
        drain("wide divisor");
        wr(REG_BAUD_OFS, 32'h0009);
        wr(REG_CTRL_OFS, cfg(8'h00));
        m_period <= 16'd10;
        repeat (20) @(posedge pclk);
        wr(REG_DATA_OFS, {23'h0, 9'($urandom)});
        wr(REG_CTRL_OFS, 32'h4);
        repeat (3) @(posedge pclk);
        chk({31'h0, tx_pin_o}, 32'h1, "abort idle");
        wr(REG_CTRL_OFS, cfg(8'(1 << CTRL_INV_BIT) | 8'(1 << CTRL_SYNC_BIT)));
        wr(REG_DATA_OFS, {23'h0, 9'($urandom)});
        repeat (150) @(posedge pclk);
        chk({31'h0, tx_pin_o}, 32'h1, "clocked mode idle");
        drain("abort and clocked mode");
        end_sim;
    end
endmodule // tb_async_serial_transmitter

`default_nettype wire
